//--- src/watchdog_reset_timer.sv
// Watchdog reset timer: restart key, write-once mode, pause in HALT/STOP.
// Assumes single-cycle CPU write/read strobes and per-source tick enables.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Correct key write clears the counter; counting restarts from zero
// - Reset loads the restart-key register with its reset pattern
// - Key register reads always return the reset pattern
// - Wrong key write raises internal reset while operating
// - Bit access to key register raises internal reset while operating
// - Reset causes seen with source clock stopped wait until it runs
// - Counter reaching selected interval raises internal reset
// - Mode register writable once; second write raises reset when operating
// - After software stop, misuse raises no reset
// - Non-stoppable option always counts internal oscillator, even in STOP
// - Non-stoppable option ignores clock select bits 3 and 4
// - After reset, counts internal oscillator at maximum interval
// - Any mode register write clears the counter
// - Stoppable option: mode selects oscillator, high-speed clock or stop
// - Stoppable option pauses in HALT/STOP, resumes keeping count
// - High-speed CPU and watchdog: wait settle time after STOP
// - Oscillator CPU, high-speed watchdog: resume on settle or CPU switch
// - Oscillator watchdog clock resumes immediately after STOP
// - Interval code selects 2^11..2^18 osc or 2^13..2^20 fast cycles
// - Clock select: 00 oscillator, 01 high-speed, 1x stopped
// - Clearing stop bit does not restart the watchdog, no reset
module watchdog_reset_timer
   import wdt_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic clk_en,
   // Option strap and clock ticks
   input wire logic stoppable_opt,
   input wire logic osc_tick,
   input wire logic hs_tick,
   // CPU state
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic cpu_on_hs,
   input wire logic settle_done,
   // CPU register port
   input wire logic [15:0] addr,
   input wire logic wr_en,
   input wire logic bit_op,
   input wire logic rd_en,
   input wire logic [7:0] wr_data,
   // Outputs
   output logic [7:0] rd_data,
   output logic wdt_reset,
   output logic [CNT_W-1:0] count
);
   import wdt_pkg::*;

   typedef enum logic [1:0] {RUN, SETTLE} resume_t;

   logic [7:0] mode_q;
   logic mode_written_q;
   logic sw_stopped_q;
   logic pending_q;
   logic [CNT_W-1:0] count_q;
   resume_t rs_q;
   logic [7:0] rd_data_q;
   logic wdt_reset_q;
   logic was_stop_q;
   logic cpu_on_hs_q;

   wire mode_wr = clk_en && wr_en && addr == MODE_ADDR;
   wire key_acc = clk_en && (wr_en || bit_op) && addr == KEY_ADDR;
   // Bit access or non-key byte counts as misuse
   wire key_bad = key_acc && (bit_op || wr_data != KEY_VALUE);
   wire key_ok = key_acc && !key_bad;
   wire hs_sel = stoppable_opt && mode_q[SRC_BIT];
   wire src_tick = hs_sel ? hs_tick : osc_tick;
   // Stoppable option freezes in standby; fixed option never does
   wire standby = stoppable_opt && (halt_mode || stop_mode);
   wire stop_release = was_stop_q && !stop_mode;
   // Fast watchdog clock waits; oscillator resumes
   wire need_settle = stoppable_opt && stop_release && hs_sel;
   // Release cycle counts as settling so a pending reset cannot slip out
   wire settling = rs_q == SETTLE || need_settle;
   wire cpu_switch = cpu_on_hs && !cpu_on_hs_q;
   wire src_run = !standby && !settling;
   wire active = !sw_stopped_q;
   wire [4:0] exp_v = hs_sel ? 5'(HS_BASE_EXP) + 5'(mode_q[IVL_HI:0])
                             : 5'(OSC_BASE_EXP) + 5'(mode_q[IVL_HI:0]);
   // Terminal count per code, doubling each step
   wire [CNT_W:0] limit = (CNT_W+1)'(1) << exp_v;
   wire overflow = active && src_run && src_tick
                   && ({1'b0, count_q} + 1'b1 == limit);
   wire misuse = active && (key_bad || (mode_wr && mode_written_q));
   // Misuse with stopped source waits for the source to run
   wire fire = overflow || ((misuse || pending_q) && src_run);
   // Fixed option keeps clock select bits cleared
   wire [7:0] mode_new = stoppable_opt ? {MODE_FIXED_TOP, wr_data[4:0]}
                                       : {MODE_FIXED_TOP, 2'b00, wr_data[2:0]};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= MODE_RESET;
         mode_written_q <= 1'b0;
         sw_stopped_q <= 1'b0;
         pending_q <= 1'b0;
         was_stop_q <= 1'b0;
         cpu_on_hs_q <= 1'b0;
         rs_q <= RUN;
      end else if (clk_en) begin
         was_stop_q <= stop_mode;
         cpu_on_hs_q <= cpu_on_hs;
         if (mode_wr && !mode_written_q) begin
            mode_q <= mode_new;
            mode_written_q <= 1'b1;
            sw_stopped_q <= stoppable_opt && wr_data[STOP_BIT];
         end
         pending_q <= (pending_q || misuse) && !src_run;
         case (rs_q)
            RUN: begin
               if (need_settle) begin
                  rs_q <= SETTLE;
               end
            end
            SETTLE: begin
               if (settle_done || cpu_switch) begin
                  rs_q <= RUN;
               end
            end
            default: rs_q <= RUN;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q <= '0;
      end else if (clk_en) begin
         if (key_ok || mode_wr) begin
            count_q <= '0;
         end else if (active && src_run && src_tick) begin
            count_q <= overflow ? '0 : count_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data_q <= 8'h00;
         wdt_reset_q <= 1'b0;
      end else if (clk_en) begin
         wdt_reset_q <= fire;
         if (rd_en && addr == KEY_ADDR) begin
            rd_data_q <= KEY_RESET;
         end else if (rd_en && addr == MODE_ADDR) begin
            rd_data_q <= mode_q;
         end else begin
            rd_data_q <= 8'h00;
         end
      end
   end

   assign rd_data = rd_data_q;
   assign wdt_reset = wdt_reset_q;
   assign count = count_q;

   property p_key_clear;
      @(posedge clk) disable iff (!reset_n)
      key_ok |=> count_q == '0;
   endproperty
   a_key_clear: assert property (p_key_clear) else $error("key no clear");

   property p_key_read;
      @(posedge clk) disable iff (!reset_n)
      clk_en && rd_en && addr == KEY_ADDR |=> rd_data == KEY_RESET;
   endproperty
   a_key_read: assert property (p_key_read) else $error("key read");

   property p_bad_key;
      @(posedge clk) disable iff (!reset_n)
      key_bad && active && src_run |=> wdt_reset;
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("bad key");

   property p_stopped_quiet;
      @(posedge clk) disable iff (!reset_n)
      sw_stopped_q && !pending_q |=> !wdt_reset;
   endproperty
   a_stopped_quiet: assert property (p_stopped_quiet) else $error("stop rst");

   property p_mode_clear;
      @(posedge clk) disable iff (!reset_n)
      mode_wr |=> count_q == '0;
   endproperty
   a_mode_clear: assert property (p_mode_clear) else $error("mode clr");

   property p_hold;
      @(posedge clk) disable iff (!reset_n)
      clk_en && standby && !key_ok && !mode_wr |=> $stable(count_q);
   endproperty
   a_hold: assert property (p_hold) else $error("standby count");

   property p_fixed_src;
      @(posedge clk) disable iff (!reset_n)
      !stoppable_opt |-> !hs_sel && !sw_stopped_q;
   endproperty
   a_fixed_src: assert property (p_fixed_src) else $error("fixed src");

   property p_pending;
      @(posedge clk) disable iff (!reset_n)
      clk_en && pending_q && src_run |=> wdt_reset;
   endproperty
   a_pending: assert property (p_pending) else $error("pending");

   property p_reset_mode;
      @(posedge clk) disable iff (!reset_n)
      !mode_written_q |-> mode_q == MODE_RESET;
   endproperty
   a_reset_mode: assert property (p_reset_mode) else $error("rst mode");

   property p_reset_src;
      @(posedge clk) disable iff (!reset_n)
      !mode_written_q |-> !hs_sel && !sw_stopped_q;
   endproperty
   a_reset_src: assert property (p_reset_src) else $error("rst src");

   property p_bit_key;
      @(posedge clk) disable iff (!reset_n)
      key_acc && bit_op && active && src_run |=> wdt_reset;
   endproperty
   a_bit_key: assert property (p_bit_key) else $error("bit key");

   property p_overflow;
      @(posedge clk) disable iff (!reset_n)
      clk_en && overflow |=> wdt_reset;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow");

   property p_overflow_wrap;
      @(posedge clk) disable iff (!reset_n)
      clk_en && overflow && !key_ok && !mode_wr |=> count_q == '0;
   endproperty
   a_overflow_wrap: assert property (p_overflow_wrap) else $error("wrap");

   property p_second_mode;
      @(posedge clk) disable iff (!reset_n)
      mode_wr && mode_written_q && active && src_run |=> wdt_reset;
   endproperty
   a_second_mode: assert property (p_second_mode) else $error("mode 2");

   property p_mode_once;
      @(posedge clk) disable iff (!reset_n)
      mode_wr && mode_written_q |=> $stable(mode_q);
   endproperty
   a_mode_once: assert property (p_mode_once) else $error("mode once");

   property p_fixed_run;
      @(posedge clk) disable iff (!reset_n)
      !stoppable_opt |-> src_run && !standby;
   endproperty
   a_fixed_run: assert property (p_fixed_run) else $error("fixed run");

   property p_fixed_count;
      @(posedge clk) disable iff (!reset_n)
      clk_en && !stoppable_opt && osc_tick && !key_ok && !mode_wr
         && !overflow |=> count_q == $past(count_q) + 1'b1;
   endproperty
   a_fixed_count: assert property (p_fixed_count) else $error("fix cnt");

   property p_fixed_bits;
      @(posedge clk) disable iff (!reset_n)
      !stoppable_opt |-> mode_q[STOP_BIT:SRC_BIT] == 2'b00;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("fix bits");

   property p_src_latch;
      @(posedge clk) disable iff (!reset_n)
      clk_en && mode_wr && !mode_written_q && stoppable_opt
         |=> mode_q[SRC_BIT] == $past(wr_data[SRC_BIT]);
   endproperty
   a_src_latch: assert property (p_src_latch) else $error("src sel");

   property p_stop_latch;
      @(posedge clk) disable iff (!reset_n)
      clk_en && mode_wr && !mode_written_q && stoppable_opt
         |=> sw_stopped_q == $past(wr_data[STOP_BIT]);
   endproperty
   a_stop_latch: assert property (p_stop_latch) else $error("stop sel");

   property p_top_bits;
      @(posedge clk) disable iff (!reset_n)
      mode_q[7:STOP_BIT+1] == MODE_FIXED_TOP;
   endproperty
   a_top_bits: assert property (p_top_bits) else $error("top bits");

   property p_mode_read;
      @(posedge clk) disable iff (!reset_n)
      clk_en && rd_en && addr == MODE_ADDR |=> rd_data == $past(mode_q);
   endproperty
   a_mode_read: assert property (p_mode_read) else $error("mode read");

   property p_count_run;
      @(posedge clk) disable iff (!reset_n)
      clk_en && active && src_run && src_tick && !overflow && !key_ok
         && !mode_wr |=> count_q == $past(count_q) + 1'b1;
   endproperty
   a_count_run: assert property (p_count_run) else $error("count run");

   property p_settle_enter;
      @(posedge clk) disable iff (!reset_n)
      clk_en && need_settle |=> rs_q == SETTLE;
   endproperty
   a_settle_enter: assert property (p_settle_enter) else $error("settle");

   property p_settle_hold;
      @(posedge clk) disable iff (!reset_n)
      clk_en && settling && !key_ok && !mode_wr |=> $stable(count_q);
   endproperty
   a_settle_hold: assert property (p_settle_hold) else $error("settle cnt");

   property p_settle_exit;
      @(posedge clk) disable iff (!reset_n)
      clk_en && rs_q == SETTLE && (settle_done || cpu_switch)
         |=> rs_q == RUN;
   endproperty
   a_settle_exit: assert property (p_settle_exit) else $error("settle end");

   property p_osc_resume;
      @(posedge clk) disable iff (!reset_n)
      clk_en && stop_release && !hs_sel && rs_q == RUN |=> rs_q == RUN;
   endproperty
   a_osc_resume: assert property (p_osc_resume) else $error("osc resume");

   property p_osc_limit;
      @(posedge clk) disable iff (!reset_n)
      !hs_sel && mode_q[IVL_HI:0] == IVL_MAX
         |-> limit == (CNT_W+1)'(1) << (OSC_BASE_EXP + IVL_MAX);
   endproperty
   a_osc_limit: assert property (p_osc_limit) else $error("osc limit");

   property p_hs_limit;
      @(posedge clk) disable iff (!reset_n)
      hs_sel && mode_q[IVL_HI:0] == IVL_MAX |-> limit[CNT_W] == 1'b1;
   endproperty
   a_hs_limit: assert property (p_hs_limit) else $error("fast limit");

   property p_stop_kept;
      @(posedge clk) disable iff (!reset_n)
      sw_stopped_q |=> sw_stopped_q;
   endproperty
   a_stop_kept: assert property (p_stop_kept) else $error("stop kept");

   property p_stop_frozen;
      @(posedge clk) disable iff (!reset_n)
      sw_stopped_q && !key_ok && !mode_wr |=> $stable(count_q);
   endproperty
   a_stop_frozen: assert property (p_stop_frozen) else $error("stop cnt");

   property p_pending_wait;
      @(posedge clk) disable iff (!reset_n)
      clk_en && misuse && !src_run |=> pending_q && !wdt_reset;
   endproperty
   a_pending_wait: assert property (p_pending_wait) else $error("wait");
endmodule
`default_nettype wire

//--- pkg/wdt_pkg.sv
// Package for the watchdog reset timer: register map, fields, reset values.
// Assumes an 8-bit CPU register port and tick enables for each clock source.
package wdt_pkg;
   localparam logic [15:0] MODE_ADDR = 16'hFF98;
   localparam logic [15:0] KEY_ADDR = 16'hFF99;
   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [7:0] KEY_RESET = 8'h9A;
   localparam logic [7:0] KEY_VALUE = 8'hAC;
   localparam logic [2:0] MODE_FIXED_TOP = 3'h3;
   localparam int STOP_BIT = 4;
   localparam int SRC_BIT = 3;
   localparam int IVL_HI = 2;
   localparam int CNT_W = 20;
   localparam int OSC_BASE_EXP = 11;
   localparam int HS_BASE_EXP = 13;
   localparam logic [2:0] IVL_MAX = 3'h7;
endpackage

//--- bench/cpu_sw_model.sv
// CPU software model driving the watchdog register port.
// Assumes the bench clock; requests change 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module cpu_sw_model
   import wdt_pkg::*;
(
   // Register port
   input wire logic clk,
   output logic [15:0] addr,
   output logic wr_en,
   output logic bit_op,
   output logic rd_en,
   output logic [7:0] wr_data
);
   initial {addr, wr_en, bit_op, rd_en, wr_data} = '0;
   // k: byte write, bit access, read; held one edge
   task automatic acc(input logic [15:0] a, input logic [7:0] d,
      input logic [2:0] k);
      @(posedge clk) #1 {wr_en, bit_op, rd_en} = k;
      addr = a;
      wr_data = (a == MODE_ADDR) ? {MODE_FIXED_TOP, d[4:0]} : d;
      @(posedge clk) #1 {wr_en, bit_op, rd_en} = 3'h0;
   endtask
endmodule
`default_nettype wire

//--- bench/watchdog_reset_timer_bench.sv
// Self-checking bench for the watchdog reset timer.
// Assumes cpu_sw_model drives the register port.
`timescale 1ns/1ps
`default_nettype none
`define C(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   miscompares++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module watchdog_reset_timer_bench;
   import wdt_pkg::*;
   logic clk = 0, reset_n = 0, opt = 1, ot = 0, ht = 0, hm = 0, sm = 0;
   logic hs = 0, sd = 0, hit = 0, wr_en, bit_op, rd_en, wdt_reset;
   logic [15:0] addr;
   logic [7:0] wr_data, rd_data, d;
   logic [CNT_W-1:0] count;
   int miscompares = 0, checks_done = 0, cyc = 0, ex = 0;
   always #2.5 clk = ~clk;
   // Sticky catch of the one-cycle reset pulse
   always @(posedge clk) begin
      cyc++;
      if (wdt_reset === 1'b1) hit = 1;
      if (cyc == 6000) begin
         miscompares++;
         close_out();
      end
   end
   watchdog_reset_timer watchdog_reset_timer_inst (.clk(clk),
      .reset_n(reset_n), .clk_en(1'b1), .stoppable_opt(opt),
      .osc_tick(ot), .hs_tick(ht), .halt_mode(hm), .stop_mode(sm),
      .cpu_on_hs(hs), .settle_done(sd), .addr(addr), .wr_en(wr_en),
      .bit_op(bit_op), .rd_en(rd_en), .wr_data(wr_data),
      .rd_data(rd_data), .wdt_reset(wdt_reset), .count(count));
   cpu_sw_model cpu_sw_model_inst (.clk(clk), .addr(addr), .wr_en(wr_en),
      .bit_op(bit_op), .rd_en(rd_en), .wr_data(wr_data));
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rst(input logic o);
      reset_n = 0;
      opt = o;
      repeat (20) @(posedge clk);
      #1 reset_n = 1;
      hit = 0;
      ex = 0;
   endtask
   // g: counts per tick in the model, negative skips the compare
   task automatic tk(input int n, input logic o, input logic h, input int g);
      repeat (n) @(posedge clk) #1 {ot, ht} = {o, h};
      @(posedge clk) #1 {ot, ht} = 2'h0;
      if (g >= 0) ex += g * n;
      if (g >= 0) `C("count", 20'(ex), count)
   endtask
   task automatic ck(input logic r);
      repeat (3) @(posedge clk);
      #1 `C("reset", r, hit)
      hit = 0;
   endtask
   task automatic op(input logic [15:0] a, input logic [7:0] v,
      input logic [2:0] k, input logic r);
      cpu_sw_model_inst.acc(a, v, k);
      if (k == 3'h4 && (a == MODE_ADDR || v == KEY_VALUE)) ex = 0;
      ck(r);
   endtask
   initial begin
      void'($urandom(32'h3BB900A3));
      rst(1);
      cpu_sw_model_inst.acc(KEY_ADDR, 8'h00, 3'h1);
      `C("key", KEY_RESET, rd_data)
      cpu_sw_model_inst.acc(MODE_ADDR, 8'h00, 3'h1);
      `C("mode", MODE_RESET, rd_data)
      tk(10, 1, 1, 1);
      op(KEY_ADDR, KEY_VALUE, 3'h4, 0);
      tk(5, 1, 0, 1);
      cpu_sw_model_inst.acc(KEY_ADDR, 8'h00, 3'h1);
      `C("key", KEY_RESET, rd_data)
      d = 8'($urandom);
      if (d == KEY_VALUE) d = 8'h55;
      op(KEY_ADDR, d, 3'h4, 1);
      op(KEY_ADDR, KEY_VALUE, 3'h2, 1);
      op(MODE_ADDR, 8'h60, 3'h4, 0);
      tk(2047, 1, 0, 1);
      ck(0);
      tk(1, 1, 0, -1);
      ck(1);
      op(MODE_ADDR, 8'h60, 3'h4, 1);
      $display("test key and overflow done");
      rst(1);
      op(MODE_ADDR, 8'h69, 3'h4, 0);
      tk(7, 0, 1, 1);
      tk(5, 1, 0, 0);
      hm = 1;
      tk(9, 1, 1, 0);
      hm = 0;
      tk(3, 0, 1, 1);
      sm = 1;
      op(KEY_ADDR, 8'h55, 3'h4, 0);
      tk(4, 1, 1, 0);
      sm = 0;
      tk(4, 1, 1, 0);
      `C("reset", 1'b0, hit)
      sd = 1;
      tk(2, 0, 1, 1);
      ck(1);
      sd = 0;
      sm = 1;
      tk(2, 1, 1, 0);
      sm = 0;
      tk(3, 0, 1, 0);
      hs = 1;
      tk(2, 0, 1, 1);
      sm = 1;
      tk(2, 0, 1, 0);
      sm = 0;
      tk(3, 0, 1, 0);
      sd = 1;
      tk(2, 0, 1, 1);
      sd = 0;
      hs = 0;
      ck(0);
      $display("test pause done");
      rst(1);
      op(MODE_ADDR, 8'h70, 3'h4, 0);
      op(MODE_ADDR, 8'h60, 3'h4, 0);
      op(KEY_ADDR, 8'h55, 3'h4, 0);
      op(KEY_ADDR, KEY_VALUE, 3'h2, 0);
      tk(6, 1, 1, 0);
      $display("test software stop done");
      rst(0);
      op(MODE_ADDR, 8'h78, 3'h4, 0);
      cpu_sw_model_inst.acc(MODE_ADDR, 8'h00, 3'h1);
      `C("mode", {MODE_FIXED_TOP, 5'h00}, rd_data)
      tk(6, 1, 0, 1);
      tk(3, 0, 1, 0);
      sm = 1;
      tk(4, 1, 0, 1);
      sm = 0;
      $display("test fixed option done");
      close_out();
   end
endmodule
`default_nettype wire
